/* File: spi_status_and_data_port.sv */
// Serial peripheral port: data, control and control/status registers
// Assumes one-cycle strobes, read data one cycle later, sync pin inputs
//
// Functional notes
// R01: Done flag sets at byte end; status read then data access clears.
// R02: Interrupt request while done flag set and interrupt enable on.
// R03: Data writes ignored while done set until status is read.
// R04: Write collision flag sets on data write during shifting.
// R05: Overrun flag sets when byte completes while done still set.
// R06: Reading control/status clears the overrun flag.
// R07: Select low in master role sets mode fault, may interrupt.
// R08: Mode fault clears by status read with flag set, then control write.
// R09: Software writes zero to reserved status bit 3.
// R10: Output disable stops driving data output; needs port enable.
// R11: Software select control ignores the select pin, uses select level.
// R12: Select level drives internal select: 0 selects, 1 deselects.
// R13: Master data write starts a full-duplex byte transfer.
// R14: Received byte copied to buffer at done; reads return buffer.
// R15: Data write loads shift register directly, no transmit buffer.
// R16: Reset clears whole control/status register.
// R17: Mode fault clears port enable and master role.
// R18: Divider bits pick clock divide by 4 to 128 in master role.
// R19: Polarity sets idle level, phase picks capture edge; both ends match.
// R20: Status read then data access clears write collision flag.
// R21: Eight bits per transfer, msb first, one bit each way per period.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spi_status_and_data_port #(
  parameter int ADDR_W = 8
) (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [spi_port_pkg::REG_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [spi_port_pkg::REG_W-1:0] reg_rdata,
  output logic                          irq,
  input  wire logic                     sck_in,
  output logic                          sck_out,
  output logic                          sck_oe,
  input  wire logic                     mosi_in,
  output logic                          mosi_out,
  output logic                          mosi_oe,
  input  wire logic                     miso_in,
  output logic                          miso_out,
  output logic                          miso_oe,
  input  wire logic                     ss_n_in
);
  import spi_port_pkg::*;

  generate
    if (ADDR_W < 6 || ADDR_W > 16) begin : g_bad_addr_w
      $error("ADDR_W must be 6 to 16");
    end
  endgenerate

  shift_if sif ();

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] rx_buf_reg;
  logic       done_reg;
  logic       write_collision_flag_reg;
  logic       ovr_reg;
  logic       mode_fault_flag_reg;
  logic       sod_reg;
  logic       ssm_reg;
  logic       ssi_reg;
  logic       sts_seen_reg;
  logic       mode_fault_flag_seen_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;
  logic       eng_sck;
  logic       eng_dout;

  // Address decode
  wire hit_data = reg_addr == ADDR_W'(OFF_DATA);
  wire hit_ctrl = reg_addr == ADDR_W'(OFF_CTRL);
  wire hit_sts  = reg_addr == ADDR_W'(OFF_STATUS);

  wire data_wr  = reg_wr && hit_data;
  wire data_rd  = reg_rd && hit_data;
  wire ctrl_wr  = reg_wr && hit_ctrl;
  wire sts_wr   = reg_wr && hit_sts;
  wire sts_rd   = reg_rd && hit_sts;
  wire data_acc = data_wr || data_rd;

  wire irq_en   = ctrl_reg[CTRL_IRQ_EN];
  wire port_en  = ctrl_reg[CTRL_PORT_EN];
  wire master   = ctrl_reg[CTRL_MASTER];

  // R11: pin ignored under software control
  // R12: select level drives internal select
  wire ss_int_n = ssm_reg ? ssi_reg : ss_n_in;

  // R07: select low in master role
  wire mode_fault_flag_event = master && !ss_int_n;

  // R03: writes blocked until status read
  wire wr_allowed = !done_reg || sts_seen_reg;
  wire wr_taken   = data_wr && wr_allowed;

  // R04: write during shifting
  wire write_collision_flag_event = wr_taken && sif.busy;
  // R15: load straight into shifter
  wire load_ok    = wr_taken && !sif.busy;

  // R01: status read then data access
  wire seq_clear  = sts_seen_reg && data_acc;
  // R05: byte completes with done still set
  wire ovr_event  = sif.done && done_reg;
  // R08: armed by status read, fired by control write
  wire mode_fault_flag_clear = mode_fault_flag_seen_reg && ctrl_wr;

  // Control register next value
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = reg_wdata;
    end
    // R17: fault drops enable and master role
    if (mode_fault_flag_event) begin
      ctrl_next[CTRL_PORT_EN] = 1'b0;
      ctrl_next[CTRL_MASTER]  = 1'b0;
    end
  end

  // Engine hookup
  assign sif.start    = load_ok && master && port_en;
  assign sif.load     = load_ok;
  assign sif.tx_byte  = reg_wdata;
  assign sif.master   = master;
  assign sif.enable   = port_en;
  assign sif.selected = !ss_int_n;
  assign sif.clock_idle_level     = ctrl_reg[CTRL_CLOCK_IDLE_LEVEL];
  assign sif.clock_capture_phase     = ctrl_reg[CTRL_CLOCK_CAPTURE_PHASE];
  assign sif.div_code = {ctrl_reg[CTRL_DIV_HALF], ctrl_reg[CTRL_DIV_HI],
                         ctrl_reg[CTRL_DIV_LO]};

  spi_shift_engine u_engine (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .bus     (sif),
    .sck_in  (sck_in),
    .din     (master ? miso_in : mosi_in),
    .sck_out (eng_sck),
    .dout    (eng_dout)
  );

  // Control register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Read sequence trackers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sts_seen_reg  <= 1'b0;
      mode_fault_flag_seen_reg <= 1'b0;
    end else begin
      if (sts_rd) begin
        sts_seen_reg <= 1'b1;
      end else if (data_acc) begin
        sts_seen_reg <= 1'b0;
      end
      if (sts_rd && mode_fault_flag_reg) begin
        mode_fault_flag_seen_reg <= 1'b1;
      end else if (ctrl_wr) begin
        mode_fault_flag_seen_reg <= 1'b0;
      end
    end
  end

  // Status flags, set wins over clear
  always_ff @(posedge clk_sys) begin
    // R16: whole status cleared
    if (sys_rst) begin
      done_reg <= STATUS_RESET[STS_DONE];
      write_collision_flag_reg <= STATUS_RESET[STS_WRITE_COLLISION_FLAG];
      ovr_reg  <= STATUS_RESET[STS_OVR];
      mode_fault_flag_reg <= STATUS_RESET[STS_MODE_FAULT_FLAG];
      sod_reg  <= STATUS_RESET[STS_SOD];
      ssm_reg  <= STATUS_RESET[STS_SSM];
      ssi_reg  <= STATUS_RESET[STS_SSI];
    end else begin
      // R01: done flag set and cleared
      if (sif.done) begin
        done_reg <= 1'b1;
      end else if (seq_clear) begin
        done_reg <= 1'b0;
      end
      // R20: collision cleared by sequence
      if (write_collision_flag_event) begin
        write_collision_flag_reg <= 1'b1;
      end else if (seq_clear) begin
        write_collision_flag_reg <= 1'b0;
      end
      // R06: status read clears overrun
      if (ovr_event) begin
        ovr_reg <= 1'b1;
      end else if (sts_rd) begin
        ovr_reg <= 1'b0;
      end
      // R07: mode fault flag
      if (mode_fault_flag_event) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (mode_fault_flag_clear) begin
        mode_fault_flag_reg <= 1'b0;
      end
      // R09: reserved bit not stored
      if (sts_wr) begin
        sod_reg <= reg_wdata[STS_SOD];
        ssm_reg <= reg_wdata[STS_SSM];
        ssi_reg <= reg_wdata[STS_SSI];
      end
    end
  end

  // R14: buffer loads at done, not on overrun
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_buf_reg <= DATA_RESET;
    end else if (sif.done && !done_reg) begin
      rx_buf_reg <= sif.rx_byte;
    end
  end

  // Read data mux
  wire [7:0] sts_view = {done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg,
                         1'b0, sod_reg, ssm_reg, ssi_reg};
  wire [7:0] rd_mux = hit_data ? rx_buf_reg :
                      hit_ctrl ? ctrl_reg   :
                      hit_sts  ? sts_view   : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // R02: request from flags and enable
  // R05: overrun also requests
  wire irq_next = irq_en && (done_reg || ovr_reg || mode_fault_flag_reg);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = irq_reg;

  // R10: output gated by disable and enable
  wire out_en = port_en && !sod_reg;

  assign sck_out  = eng_sck;
  assign sck_oe   = port_en && master;
  assign mosi_out = master ? eng_dout : 1'b0;
  assign mosi_oe  = out_en && master;
  assign miso_out = master ? 1'b0 : eng_dout;
  assign miso_oe  = out_en && !master && !ss_int_n;

endmodule // spi_status_and_data_port
`default_nettype wire

/* File: spi_port_pkg.sv */
// Package: register map, field positions, reset values, divider decode
// Assumes byte-wide registers reached over a simple strobe port
package spi_port_pkg;

  localparam int REG_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_DATA   = 8'h21;
  localparam logic [7:0] OFF_CTRL   = 8'h22;
  localparam logic [7:0] OFF_STATUS = 8'h23;

  // Control register fields
  localparam int CTRL_IRQ_EN   = 7;
  localparam int CTRL_PORT_EN  = 6;
  localparam int CTRL_DIV_HALF = 5;
  localparam int CTRL_MASTER   = 4;
  localparam int CTRL_CLOCK_IDLE_LEVEL     = 3;
  localparam int CTRL_CLOCK_CAPTURE_PHASE     = 2;
  localparam int CTRL_DIV_HI   = 1;
  localparam int CTRL_DIV_LO   = 0;

  // Control/status register fields
  localparam int STS_DONE   = 7;
  localparam int STS_WRITE_COLLISION_FLAG   = 6;
  localparam int STS_OVR    = 5;
  localparam int STS_MODE_FAULT_FLAG   = 4;
  localparam int STS_RSVD   = 3;
  localparam int STS_SOD    = 2;
  localparam int STS_SSM    = 1;
  localparam int STS_SSI    = 0;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  // Edge index of the last of sixteen clock transitions
  localparam logic [3:0] EDGE_LAST = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } shift_state_t;

  // Half period minus one, in system clocks, from {half_dis, hi, lo}
  function automatic logic [5:0] half_period(input logic [2:0] code);
    case (code)
      3'h4:    half_period = 6'h01;
      3'h0:    half_period = 6'h03;
      3'h1:    half_period = 6'h07;
      3'h6:    half_period = 6'h0F;
      3'h2:    half_period = 6'h1F;
      3'h3:    half_period = 6'h3F;
      default: half_period = 6'h3F;
    endcase
  endfunction

endpackage

/* File: shift_if.sv */
// Interface between register front end and bit shift engine
// Assumes both ends share clk_sys
`timescale 1ns/1ps
`default_nettype none
interface shift_if;
  logic       start;
  logic       load;
  logic [7:0] tx_byte;
  logic       master;
  logic       enable;
  logic       selected;
  logic       clock_idle_level;
  logic       clock_capture_phase;
  logic [2:0] div_code;
  logic [7:0] rx_byte;
  logic       done;
  logic       busy;

  modport ctrl (
    output start, load, tx_byte, master, enable, selected,
    output clock_idle_level, clock_capture_phase, div_code,
    input  rx_byte, done, busy
  );
  modport eng (
    input  start, load, tx_byte, master, enable, selected,
    input  clock_idle_level, clock_capture_phase, div_code,
    output rx_byte, done, busy
  );
endinterface
`default_nettype wire

/* File: spi_shift_engine.sv */
// Bit engine: master clock divider, edge counting, shift registers
// Assumes pin inputs synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module spi_shift_engine (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  shift_if.eng      bus,
  input  wire logic sck_in,
  input  wire logic din,
  output logic      sck_out,
  output logic      dout
);
  import spi_port_pkg::*;

  shift_state_t state_reg, state_next;
  logic [5:0]   div_cnt_reg;
  logic         sck_reg;
  logic         sck_prev_reg;
  logic [3:0]   edge_cnt_reg;
  logic [7:0]   tx_reg;
  logic [7:0]   rx_reg;
  logic         done_reg;

  wire running   = state_reg == ST_RUN;
  // R18: divider select
  wire half_tick = div_cnt_reg == half_period(bus.div_code);
  wire m_edge    = bus.master && running && half_tick;
  wire s_active  = bus.enable && !bus.master && bus.selected;
  wire s_edge    = s_active && (sck_in != sck_prev_reg);
  wire any_edge  = m_edge || s_edge;
  // R19: phase picks capture edge
  wire sample_edge = edge_cnt_reg[0] == bus.clock_capture_phase;
  // R21: eight bits, sixteen edges
  wire last_edge = any_edge && (edge_cnt_reg == EDGE_LAST);
  wire abort     = !bus.enable || (!bus.master && !bus.selected);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (bus.start && bus.master && bus.enable) begin
          state_next = ST_RUN;
        end else if (s_edge) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (abort || last_edge) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      div_cnt_reg  <= 6'h00;
      sck_reg      <= 1'b0;
      sck_prev_reg <= 1'b0;
      edge_cnt_reg <= 4'h0;
      tx_reg       <= DATA_RESET;
      rx_reg       <= DATA_RESET;
      done_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sck_prev_reg <= sck_in;
      done_reg     <= last_edge;
      div_cnt_reg  <= (!running || half_tick) ? 6'h00 : div_cnt_reg + 6'h01;
      if (abort || last_edge) begin
        edge_cnt_reg <= 4'h0;
      end else if (any_edge) begin
        edge_cnt_reg <= edge_cnt_reg + 4'h1;
      end
      // R19: idle level from polarity
      if (!bus.master || !running) begin
        sck_reg <= bus.clock_idle_level;
      end else if (m_edge) begin
        sck_reg <= ~sck_reg;
      end
      // R21: msb first out
      if (bus.load) begin
        tx_reg <= bus.tx_byte;
      end else if (any_edge && !sample_edge && edge_cnt_reg != 4'h0) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      if (any_edge && sample_edge) begin
        rx_reg <= {rx_reg[6:0], din};
      end
    end
  end

  assign bus.rx_byte = rx_reg;
  assign bus.done    = done_reg;
  assign bus.busy    = running;
  assign sck_out     = sck_reg;
  assign dout        = tx_reg[7];

endmodule // spi_shift_engine
`default_nettype wire

/* File: spi_port_monitor.sv */
// Checker on the serial port top level ports
// Assumes bind into the top module, one clock
`timescale 1ns/1ps
`default_nettype none
module spi_port_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              irq,
  input wire logic              sck_in,
  input wire logic              sck_out,
  input wire logic              sck_oe,
  input wire logic              mosi_in,
  input wire logic              mosi_out,
  input wire logic              mosi_oe,
  input wire logic              miso_in,
  input wire logic              miso_out,
  input wire logic              miso_oe,
  input wire logic              ss_n_in
);
  logic [4:0] edge_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Clock toggles since last register write
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reg_wr)
      edge_cnt <= 5'h00;
    else if (sck_oe && sck_out != $past(sck_out))
      edge_cnt <= edge_cnt + 5'h01;
  end
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  a_out_excl: assert property (!(mosi_oe && miso_oe))
    else $error("both data outputs driven");
  a_mosi_gate: assert property (mosi_oe |-> sck_oe)
    else $error("master data out without master port");
  a_miso_role: assert property (miso_oe |-> !sck_oe)
    else $error("slave data out in master role");
  a_irq_fall: assert property ($fell(irq) |->
    $past(reg_rd || reg_wr) || $past(reg_rd || reg_wr, 2))
    else $error("request dropped without access");
  a_sck_hold: assert property (sck_oe && $changed(sck_out)
    |=> $stable(sck_out))
    else $error("serial clock half period too short");
  a_bit_count: assert property (edge_cnt <= 5'h10)
    else $error("more than sixteen clock toggles");
  a_reset_quiet: assert property ($fell(sys_rst) |->
    !irq && !sck_oe && !mosi_oe && !miso_oe)
    else $error("outputs active after reset");
  c_irq: cover property ($rose(irq));
  c_master: cover property (mosi_oe && edge_cnt == 5'h10);
  c_slave: cover property (miso_oe);
endmodule // spi_port_monitor
bind spi_status_and_data_port spi_port_monitor #(.ADDR_W(ADDR_W)) mon_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .sck_in(sck_in), .sck_out(sck_out),
  .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
  .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out),
  .miso_oe(miso_oe), .ss_n_in(ss_n_in));
`default_nettype wire

/* File: spi_peer_model.sv */
// Behavioural serial slave on the far side, idle-low clock, phase 0
// Assumes arm rises with tx stable; line driven with the inverted top bit while arm is low
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       arm,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  initial rx = 8'h00;
  always @(posedge arm) sh = tx;
  // change on falling edge, msb first
  always @(negedge sck) if (arm) sh = {sh[6:0], 1'b0};
  always @(posedge sck) if (arm) rx = {rx[6:0], mosi};
  assign miso = arm ? sh[7] : ~sh[7];
endmodule // spi_peer_model
`default_nettype wire

/* File: spi_status_and_data_port_test.sv */
// Self-checking bench for the serial port
// Assumes the peer model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module spi_status_and_data_port_test;
  import spi_port_pkg::*;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       ss_n_in = 1'b1;
  logic       peer_arm = 1'b0;
  logic [7:0] peer_tx = 8'h00;
  logic       tb_sck = 1'b0;
  logic       tb_mosi = 1'b0;
  wire logic [7:0] reg_rdata, peer_rx;
  wire logic  irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  wire logic  miso_line;
  wire logic  sck_line = sck_oe ? sck_out : tb_sck;
  wire logic  mosi_line = mosi_oe ? mosi_out : tb_mosi;
  int errors = 0;
  int num_checks = 0;

  spi_status_and_data_port #(.ADDR_W(8)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .sck_in(sck_line),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_line),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_line),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
  spi_peer_model peer_u (.sck(sck_line), .mosi(mosi_line), .arm(peer_arm),
    .tx(peer_tx), .miso(miso_line), .rx(peer_rx));

  initial forever #12.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic wait_irq(input logic exp);
    for (int n = 0; n < 2000 && irq !== exp; n++) @(posedge clk_sys);
    #1 chk({7'h00, irq}, {7'h00, exp});
  endtask
  task automatic pins(input logic [2:0] exp);
    #1 chk({5'h00, sck_oe, mosi_oe, miso_oe}, {5'h00, exp});
  endtask
  task automatic peer_load(input logic [7:0] b);
    @(posedge clk_sys);
    peer_arm <= 1'b0;
    peer_tx <= b;
    @(posedge clk_sys);
    peer_arm <= 1'b1;
  endtask

  task automatic t_reset;
    rd_chk(OFF_STATUS, STATUS_RESET);
    rd_chk(OFF_CTRL, CTRL_RESET);
    rd_chk(8'h30, 8'h00);
  endtask
  task automatic t_master;
    int h;
    peer_load(8'hA5);
    wr(OFF_CTRL, 8'hD0);
    wr(OFF_DATA, 8'h3C);
    wr(OFF_DATA, 8'h99);
    for (h = 0; h < 200 && sck_line !== 1'b1; h++) begin
      @(posedge clk_sys);
      #1;
    end
    for (h = 0; h < 200 && sck_line === 1'b1; h++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(h[7:0], 8'h04);
    wait_irq(1'b1);
    chk(peer_rx, 8'h3C);
    rd_chk(OFF_STATUS, 8'hC0);
    rd_chk(OFF_DATA, 8'hA5);
    wait_irq(1'b0);
    rd_chk(OFF_STATUS, 8'h00);
  endtask
  task automatic t_inhibit;
    peer_load(8'h5A);
    wr(OFF_CTRL, 8'hF0);
    wr(OFF_DATA, 8'h81);
    wait_irq(1'b1);
    wr(OFF_DATA, 8'h42);
    repeat (20) @(posedge clk_sys);
    chk(peer_rx, 8'h81);
    peer_load(8'h66);
    rd_chk(OFF_STATUS, 8'h80);
    wr(OFF_DATA, 8'h42);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk(peer_rx, 8'h42);
    rd_chk(OFF_STATUS, 8'h80);
    rd_chk(OFF_DATA, 8'h66);
  endtask
  task automatic t_fault;
    wr(OFF_CTRL, 8'hD0);
    @(posedge clk_sys) ss_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ss_n_in <= 1'b1;
    wait_irq(1'b1);
    rd_chk(OFF_CTRL, 8'h80);
    wr(OFF_CTRL, 8'h80);
    rd_chk(OFF_STATUS, 8'h10);
    wr(OFF_CTRL, 8'h00);
    rd_chk(OFF_STATUS, 8'h00);
  endtask
  task automatic t_pins;
    wr(OFF_STATUS, 8'h07);
    wr(OFF_CTRL, 8'h50);
    @(posedge clk_sys) ss_n_in <= 1'b0;
    pins(3'b100);
    wr(OFF_STATUS, 8'h03);
    pins(3'b110);
    rd_chk(OFF_STATUS, 8'h03);
    wr(OFF_CTRL, 8'h40);
    wr(OFF_STATUS, 8'h02);
    pins(3'b001);
    wr(OFF_STATUS, 8'h03);
    pins(3'b000);
    ss_n_in <= 1'b1;
  endtask
  task automatic t_overrun;
    wr(OFF_STATUS, 8'h02);
    for (int b = 0; b < 2; b++) begin
      tb_mosi <= (b == 0);
      repeat (16) begin
        repeat (4) @(posedge clk_sys);
        tb_sck <= ~tb_sck;
      end
    end
    repeat (6) @(posedge clk_sys);
    rd_chk(OFF_STATUS, 8'hA2);
    rd_chk(OFF_STATUS, 8'h82);
    rd_chk(OFF_DATA, 8'hFF);
  endtask

  task automatic results;
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_master();
    t_inhibit();
    t_fault();
    t_pins();
    t_overrun();
    results();
  end
  initial begin
    #(25 * 20000);
    errors++;
    results();
  end
endmodule // spi_status_and_data_port_test
`default_nettype wire
